//--- fgfc_filt_dec.sv
// Purpose: turns the filter config byte into datapath controls
// Assumes: config byte comes from a register
// Notes:   outputs registered, one cycle behind the config byte
`default_nettype none

module fgfc_filt_dec (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // config byte
  input  wire logic [7:0]         cfg_i,
  // datapath controls
  output var  fgfc_pkg::fgfc_filt_t ctl_o
);
  import fgfc_pkg::*;

  logic [F_SCW_W-1:0]  scw;   // side weight field
  logic [F_SCW_W-1:0]  scw_c; // side weight clamped to legal range
  logic [F_MODE_W-1:0] mode;  // mode field

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  always_comb begin
    scw   = cfg_i[F_SCW_LSB +: F_SCW_W];
    mode  = cfg_i[F_MODE_LSB +: F_MODE_W];
    // out-of-range weight held at the top legal value
    scw_c = (scw > SCW_MAX) ? SCW_MAX : scw;
  end

  // controls: share, merge, lsb exponent, enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_o <= '{1'b0, 1'b0, 6'h00 - SCW_BIAS, 1'b0};
    end else begin
      ctl_o.b_uses_a_coef <= cfg_i[F_SHARE];
      ctl_o.merged        <= cfg_i[F_MERGE];
      ctl_o.side_lsb_exp  <= {3'b000, scw_c} - SCW_BIAS;
      // reserved codes leave the filter off
      ctl_o.enable        <= (mode == MODE_ON);
    end
  end

endmodule

`default_nettype wire

//--- fgfc_fuse_load.sv
// Purpose: copies fuse trim defaults into the gain registers after reset
// Assumes: fuse data is stable once reset has been released
// Notes:   load pulse is one cycle; ready stays high until next reset
`default_nettype none

module fgfc_fuse_load (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // fuse side
  input  wire fgfc_pkg::fgfc_gain_t fuse_i,
  // register side
  output var  fgfc_pkg::fgfc_gain_t dflt_o,
  output logic                    load_o,
  output logic                    ready_o
);
  import fgfc_pkg::*;

  fgfc_ld_t state_r;   // loader state
  fgfc_ld_t state_nxt; // next loader state

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // next state: one fetch cycle after release, then done forever
  always_comb begin
    case (state_r)
      LD_IDLE:  state_nxt = LD_FETCH;
      LD_FETCH: state_nxt = LD_DONE;
      LD_DONE:  state_nxt = LD_DONE;
      default:  state_nxt = LD_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= LD_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // fuse values caught after release, never during reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dflt_o <= '0;
    end else if (state_r == LD_IDLE) begin
      dflt_o <= fuse_i;
    end
  end

  // one-cycle load strobe and sticky ready flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_o  <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      load_o  <= (state_r == LD_FETCH);
      ready_o <= (state_r == LD_FETCH) || ready_o;
    end
  end

endmodule

`default_nettype wire

//--- fgfc_pkg.sv
// Purpose: constants and types for the fine gain and filter config bank
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   register offsets are indices; byte address is four times index
`default_nettype none

package fgfc_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 16;          // apb address width
  localparam int unsigned DATA_W     = 32;          // apb data width
  localparam int unsigned REG_W      = 8;           // register width
  localparam int unsigned GAIN_W     = 5;           // gain trim width

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_GAIN_A0 = 12'h0354;   // a bank 0 single
  localparam logic [11:0] IDX_GAIN_A1 = 12'h0355;   // a bank 1 single
  localparam logic [11:0] IDX_GAIN_B0 = 12'h0356;   // b bank 0 single
  localparam logic [11:0] IDX_GAIN_B1 = 12'h0357;   // b bank 1 single
  localparam logic [11:0] IDX_FILT    = 12'h0400;   // filter config

  localparam logic [ADDR_W-1:0] ADR_GAIN_A0 = {2'b00, IDX_GAIN_A0, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_GAIN_A1 = {2'b00, IDX_GAIN_A1, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_GAIN_B0 = {2'b00, IDX_GAIN_B0, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_GAIN_B1 = {2'b00, IDX_GAIN_B1, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_FILT    = {2'b00, IDX_FILT, 2'b00};

  // ----------------------------------------------------------------
  // reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GAIN     = 8'h00;      // before fuse load
  localparam logic [7:0] RST_FILT     = 8'h00;      // filter config
  localparam int unsigned GAIN_LSB    = 0;          // trim field 4:0
  localparam int unsigned F_SHARE     = 6;          // coefficient share
  localparam int unsigned F_MERGE     = 5;          // merge filters
  localparam int unsigned F_SCW_LSB   = 2;          // side weight 4:2
  localparam int unsigned F_SCW_W     = 3;
  localparam int unsigned F_MODE_LSB  = 0;          // mode 1:0
  localparam int unsigned F_MODE_W    = 2;
  localparam logic [2:0] SCW_MAX      = 3'h6;       // largest side weight
  localparam logic [5:0] SCW_BIAS     = 6'h10;      // exponent offset 16
  localparam logic [1:0] MODE_OFF     = 2'h0;       // filter disabled
  localparam logic [1:0] MODE_ON      = 2'h2;       // filter enabled

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // fuse defaults for the four single-channel trims
  typedef struct packed {
    logic [GAIN_W-1:0] a0;
    logic [GAIN_W-1:0] a1;
    logic [GAIN_W-1:0] b0;
    logic [GAIN_W-1:0] b1;
  } fgfc_gain_t;

  // decoded filter controls toward the datapath
  typedef struct packed {
    logic       b_uses_a_coef;  // channel b takes channel a coefficients
    logic       merged;         // both filters act as one
    logic [5:0] side_lsb_exp;   // signed exponent of side lsb weight
    logic       enable;         // filter active
  } fgfc_filt_t;

  // fuse loader states, gray along idle-fetch-done
  typedef enum logic [1:0] {
    LD_IDLE  = 2'b00,
    LD_FETCH = 2'b01,
    LD_DONE  = 2'b11
  } fgfc_ld_t;

endpackage

`default_nettype wire

//--- fgfc_regs.sv
// Purpose: apb register bank for single-channel gain trims and filter setup
// Assumes: apb4 master, zero-wait except during fuse default load
// Notes:   read data refreshed through wait states; errors set in setup
`default_nettype none

// Summary of operation
// - a0 trim in bits 4:0, 7:5 zero
// - a1 trim at index 0x355, bits 4:0
// - b0 trim at index 0x356, bits 4:0
// - b1 trim at index 0x357, bits 4:0
// - trims default from fuse memory after reset
// - filter config at 0x400, reset 0x00
// - share bit makes b use a coefficients
// - side lsb weight is two to scw-16, scw clamped at 6
// - mode 0 disables, mode 2 enables filter
module fgfc_regs (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // apb slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [fgfc_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [fgfc_pkg::DATA_W-1:0]  pwdata_i,
  input  wire logic [3:0]                   pstrb_i,
  output logic      [fgfc_pkg::DATA_W-1:0]  prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  // fuse defaults
  input  wire fgfc_pkg::fgfc_gain_t         fuse_i,
  // datapath controls
  output var  fgfc_pkg::fgfc_gain_t         gain_o,
  output var  fgfc_pkg::fgfc_filt_t         filt_o
);
  import fgfc_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0] gain_a0_r;    // fine_gain_a_bank0_single
  logic [REG_W-1:0] gain_a1_r;    // fine_gain_a_bank1_single
  logic [REG_W-1:0] gain_b0_r;    // fine_gain_b_bank0_single
  logic [REG_W-1:0] gain_b1_r;    // fine_gain_b_bank1_single
  logic [REG_W-1:0] filt_cfg_r;   // equalizer_filter_config
  fgfc_gain_t       fuse_dflt;    // captured fuse defaults
  logic             fuse_load;    // one-cycle default load strobe
  logic             fuse_ready;   // defaults in place
  logic             setup;        // apb setup cycle
  logic             wr_acc;       // write completes this edge
  logic             hit_a0;       // decoded selects
  logic             hit_a1;
  logic             hit_b0;
  logic             hit_b1;
  logic             hit_filt;
  logic             mapped;       // any register hit
  logic [REG_W-1:0] rd_mux;       // selected read byte
  logic [REG_W-1:0] wr_byte;      // masked write byte

  // ----------------------------------------------------------------
  // fuse default loader
  // ----------------------------------------------------------------
  fgfc_fuse_load u_fuse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .fuse_i  (fuse_i),
    .dflt_o  (fuse_dflt),
    .load_o  (fuse_load),
    .ready_o (fuse_ready)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // word aligned compare on full byte address
  always_comb begin
    hit_a0   = (paddr_i == ADR_GAIN_A0);
    hit_a1   = (paddr_i == ADR_GAIN_A1);
    hit_b0   = (paddr_i == ADR_GAIN_B0);
    hit_b1   = (paddr_i == ADR_GAIN_B1);
    hit_filt = (paddr_i == ADR_FILT);
    mapped   = hit_a0 | hit_a1 | hit_b0 | hit_b1 | hit_filt;
  end

  // phase qualifiers
  always_comb begin
    setup  = psel_i & ~penable_i;
    wr_acc = psel_i & penable_i & pready_o & pwrite_i & mapped;
  end

  // only lane 0 carries register data; cleared lane leaves byte alone
  always_comb begin
    wr_byte = pwdata_i[REG_W-1:0];
  end

  // ----------------------------------------------------------------
  // gain trim registers
  // ----------------------------------------------------------------
  // a bank 0: reserved bits forced zero on every load path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_a0_r <= RST_GAIN;
    end else if (wr_acc && hit_a0 && pstrb_i[0]) begin
      // software write wins over a simultaneous fuse load
      gain_a0_r <= {3'b000, wr_byte[GAIN_LSB +: GAIN_W]};
    end else if (fuse_load) begin
      gain_a0_r <= {3'b000, fuse_dflt.a0};
    end
  end

  // a bank 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_a1_r <= RST_GAIN;
    end else if (wr_acc && hit_a1 && pstrb_i[0]) begin
      gain_a1_r <= {3'b000, wr_byte[GAIN_LSB +: GAIN_W]};
    end else if (fuse_load) begin
      gain_a1_r <= {3'b000, fuse_dflt.a1};
    end
  end

  // b bank 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_b0_r <= RST_GAIN;
    end else if (wr_acc && hit_b0 && pstrb_i[0]) begin
      gain_b0_r <= {3'b000, wr_byte[GAIN_LSB +: GAIN_W]};
    end else if (fuse_load) begin
      gain_b0_r <= {3'b000, fuse_dflt.b0};
    end
  end

  // b bank 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_b1_r <= RST_GAIN;
    end else if (wr_acc && hit_b1 && pstrb_i[0]) begin
      gain_b1_r <= {3'b000, wr_byte[GAIN_LSB +: GAIN_W]};
    end else if (fuse_load) begin
      gain_b1_r <= {3'b000, fuse_dflt.b1};
    end
  end

  // ----------------------------------------------------------------
  // filter configuration register
  // ----------------------------------------------------------------
  // all eight bits stored; reserved bit 7 is plain read/write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cfg_r <= RST_FILT;
    end else if (wr_acc && hit_filt && pstrb_i[0]) begin
      filt_cfg_r <= wr_byte;
    end
  end

  // filter field decode toward the datapath
  fgfc_filt_dec u_dec (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cfg_i (filt_cfg_r),
    .ctl_o (filt_o)
  );

  // ----------------------------------------------------------------
  // gain outputs to the converter cores
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_o <= '0;
    end else begin
      gain_o.a0 <= gain_a0_r[GAIN_LSB +: GAIN_W];
      gain_o.a1 <= gain_a1_r[GAIN_LSB +: GAIN_W];
      gain_o.b0 <= gain_b0_r[GAIN_LSB +: GAIN_W];
      gain_o.b1 <= gain_b1_r[GAIN_LSB +: GAIN_W];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // byte select; unmapped reads zero
  always_comb begin
    rd_mux = '0;
    if (hit_a0) begin
      rd_mux = gain_a0_r;
    end else if (hit_a1) begin
      rd_mux = gain_a1_r;
    end else if (hit_b0) begin
      rd_mux = gain_b0_r;
    end else if (hit_b1) begin
      rd_mux = gain_b1_r;
    end else if (hit_filt) begin
      rd_mux = filt_cfg_r;
    end
  end

  // read data loaded in setup and refreshed while the slave waits,
  // so a read held across the fuse load never returns a stale word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= '0;
    end else if (psel_i && !(penable_i && pready_o)) begin
      prdata_o <= pwrite_i ? '0 : {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------------------------------
  // handshake
  // ----------------------------------------------------------------
  // ready waits for fuse defaults so no write is overwritten; it stays
  // low through the load cycle so read data refreshes from loaded trims
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= fuse_ready & ~fuse_load;
    end
  end

  // error flagged for any unmapped address, read or write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= ~mapped;
    end else if (~psel_i) begin
      pslverr_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- fgfc_regs_assertions.sv
// Purpose: concurrent checks on the gain and filter config bank ports
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to fgfc_regs after the module
`default_nettype none

module fgfc_regs_assertions
  import fgfc_pkg::*;
(
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_i,
  // apb slave
  input wire logic                psel_i,
  input wire logic                penable_i,
  input wire logic                pwrite_i,
  input wire logic [ADDR_W-1:0]   paddr_i,
  input wire logic [DATA_W-1:0]   pwdata_i,
  input wire logic [3:0]          pstrb_i,
  input wire logic [DATA_W-1:0]   prdata_o,
  input wire logic                pready_o,
  input wire logic                pslverr_o,
  // fuse and datapath
  input wire fgfc_gain_t          fuse_i,
  input wire fgfc_gain_t          gain_o,
  input wire fgfc_filt_t          filt_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic       hit;    // address maps a register
  logic       wr;     // write completes at this edge
  logic       wf;     // write to filter config completes
  logic [2:0] scw_r;  // clamped side weight last written

  assign hit = paddr_i inside {ADR_GAIN_A0, ADR_GAIN_A1, ADR_GAIN_B0,
                               ADR_GAIN_B1, ADR_FILT};
  assign wr  = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
  assign wf  = wr && (paddr_i == ADR_FILT);

  // capture clamped side weight on each filter write
  always_ff @(posedge clk_i) begin
    if (rst_i)
      scw_r <= 3'h0;
    else if (wf)
      scw_r <= (pwdata_i[4:2] > SCW_MAX) ? SCW_MAX : pwdata_i[4:2];
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ready_holds;
    pready_o |=> pready_o;
  endproperty
  a_ready_holds: assert property (p_ready_holds)
    else $error("ready dropped after load");

  property p_fuse;
    $rose(pready_o) |=> gain_o == fuse_i;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("trims not loaded from fuse");

  property p_upper_zero;
    prdata_o[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data upper bits set");

  property p_gain_rsvd;
    psel_i && !penable_i && !pwrite_i && pready_o &&
      paddr_i[15:4] == 12'h0D5 |=> prdata_o[7:5] == 3'h0;
  endproperty
  a_gain_rsvd: assert property (p_gain_rsvd)
    else $error("trim reserved bits set");

  property p_err;
    psel_i && !penable_i && pready_o |=> pslverr_o == !$past(hit);
  endproperty
  a_err: assert property (p_err)
    else $error("error flag wrong for address");

  property p_b1_out;
    wr && paddr_i == ADR_GAIN_B1 |=> ##1
      gain_o.b1 == $past(pwdata_i[4:0], 2);
  endproperty
  a_b1_out: assert property (p_b1_out)
    else $error("b1 trim not forwarded");

  property p_enable;
    wf |=> ##1 filt_o.enable == ($past(pwdata_i[1:0], 2) == MODE_ON);
  endproperty
  a_enable: assert property (p_enable)
    else $error("filter enable wrong for mode");

  property p_share;
    wf |=> ##1 {filt_o.b_uses_a_coef, filt_o.merged}
      == $past(pwdata_i[6:5], 2);
  endproperty
  a_share: assert property (p_share)
    else $error("share or merge not forwarded");

  property p_side_exp;
    wf |=> ##1 filt_o.side_lsb_exp == {3'h0, scw_r} - SCW_BIAS;
  endproperty
  a_side_exp: assert property (p_side_exp)
    else $error("side weight exponent wrong");

endmodule

bind fgfc_regs fgfc_regs_assertions i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .fuse_i(fuse_i), .gain_o(gain_o),
  .filt_o(filt_o)
);

`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the gain and filter config bank
// Assumes: apb master here, fuse defaults held constant
// Notes:   fuse defaults first, then table rows, error and strobe cases, then a second reset
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fgfc_pkg::*;

  // ----------------------------------------------------------------
  // signals and table
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] a;  // byte address
    logic [31:0] d;  // write data
    logic [31:0] q;  // read back
    logic [2:0]  k;  // trim field, 4 for filter
  } fgfc_row_t;

  localparam fgfc_gain_t FUSE = '{5'h11, 5'h0A, 5'h1F, 5'h03}; // arbitrary

  logic              clk_i, rst_i, psel_i, penable_i, pwrite_i;
  logic [15:0]       paddr_i;
  logic [31:0]       pwdata_i, prdata_o;
  logic [3:0]        pstrb_i;
  logic              pready_o, pslverr_o;
  fgfc_gain_t        fuse_i, gain_o;
  fgfc_filt_t        filt_o;
  int                mismatches, check_count;
  logic [31:0]       q;
  logic              e;
  fgfc_row_t         rows [8] = '{
    '{ADR_GAIN_A0, 32'hFFFF_FFFF, 32'h0000_001F, 3'h0},
    '{ADR_GAIN_A1, 32'h0000_0015, 32'h0000_0015, 3'h1},
    '{ADR_GAIN_B0, 32'h0000_00EA, 32'h0000_000A, 3'h2},
    '{ADR_GAIN_B1, 32'h0000_0013, 32'h0000_0013, 3'h3},
    '{ADR_FILT,    32'h0000_00C2, 32'h0000_00C2, 3'h4},
    '{ADR_FILT,    32'h0000_0021, 32'h0000_0021, 3'h4},
    '{ADR_FILT,    32'h0000_001B, 32'h0000_001B, 3'h4},
    '{ADR_FILT,    32'h0000_005C, 32'h0000_005C, 3'h4}
  };

  fgfc_regs i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .fuse_i(fuse_i), .gain_o(gain_o),
    .filt_o(filt_o)
  );

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_sim();
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, s, x);
    end
  endtask

  // one apb transfer, waits for ready under a bound
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int n;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 40);
    if (pready_o !== 1'b1) begin
      mismatches++;
      end_sim();
    end
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // read and compare data and error flag
  task rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(q, x);
    chk(32'(e), 32'(xe));
  endtask

  // expected decoded filter controls
  function automatic fgfc_filt_t fexp(input logic [7:0] c);
    fgfc_filt_t f;
    logic [2:0] w;
    w = (c[4:2] > SCW_MAX) ? SCW_MAX : c[4:2];
    f.b_uses_a_coef = c[6];
    f.merged = c[5];
    f.side_lsb_exp = {3'h0, w} - SCW_BIAS;
    f.enable = (c[1:0] == MODE_ON);
    return f;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 16'h0000;
    pwdata_i = 32'h0000_0000;
    pstrb_i = 4'h0;
    fuse_i = FUSE;
    mismatches = 0;
    check_count = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // fuse defaults and reset values, first read waits for load
    rd(ADR_GAIN_A0, 32'(FUSE.a0), 1'b0);
    rd(ADR_GAIN_B0, 32'(FUSE.b0), 1'b0);
    rd(ADR_FILT, 32'h0000_0000, 1'b0);
    chk(32'(gain_o), 32'(FUSE));
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d, 4'h1);
      repeat (2) @(posedge clk_i);
      if (rows[i].k < 3'h4)
        chk(32'(gain_o[19-5*rows[i].k -: 5]),
            32'(rows[i].q[4:0]));
      else
        chk(32'(filt_o), 32'(fexp(rows[i].d[7:0])));
      rd(rows[i].a, rows[i].q, 1'b0);
    end
    // unmapped read and write, then strobe-less write
    rd(16'h0D60, 32'h0000_0000, 1'b1);
    apb(1'b1, 16'h1004, 32'h0000_00FF, 4'h1);
    chk(32'(e), 32'h0000_0001);
    apb(1'b1, ADR_FILT, 32'h0000_00FF, 4'h0);
    chk(32'(e), 32'h0000_0000);
    rd(ADR_FILT, 32'h0000_005C, 1'b0);
    // second reset in mid-run restores defaults
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_GAIN_B1, 32'(FUSE.b1), 1'b0);
    rd(ADR_FILT, 32'h0000_0000, 1'b0);
    chk(32'(filt_o), 32'(fexp(8'h00)));
    end_sim();
  end

endmodule

`default_nettype wire
